/* caf_pkg.sv */
// package for the can acceptance filter and mask block
package caf_pkg;

  // sizes
  localparam int NUM_FILT = 16;
  localparam int NUM_MASK = 3;

  // register byte addresses
  localparam logic [7:0] ADDR_FILT_SID = 8'h00;
  localparam logic [7:0] ADDR_FILT_EID = 8'h40;
  localparam logic [7:0] ADDR_SEL_LOW = 8'h80;
  localparam logic [7:0] ADDR_SEL_HIGH = 8'h84;
  localparam logic [7:0] ADDR_MASK_SID = 8'h90;
  localparam logic [7:0] ADDR_MASK_EID = 8'hA0;
  localparam logic [7:0] ADDR_HIT_STAT = 8'hB0;

  // field positions in the standard identifier registers and the hit status word
  localparam int SID_MSB = 15;
  localparam int SID_LSB = 5;
  localparam int MODE_BIT = 3;
  localparam int EXT_TOP_MSB = 1;
  localparam int HIT_ANY_BIT = 16;

  // bits 4 and 2 are unimplemented
  localparam logic [15:0] SID_REG_WMASK = 16'hFFEB;

  // reset values
  localparam logic [15:0] SEL_RST = 16'h0000;
  localparam logic [15:0] PAT_RST = 16'h0000;

  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // mask source codes
  typedef enum logic [1:0] {
    CAF_SEL_MASK0 = 2'b00,
    CAF_SEL_MASK1 = 2'b01,
    CAF_SEL_MASK2 = 2'b10,
    CAF_SEL_NONE = 2'b11
  } caf_sel_t;

  // received frame identifier
  typedef struct packed {
    logic ext;
    logic [10:0] standard_identifier_bits;
    logic [17:0] extended_identifier_bits;
  } caf_frame_t;

  // whole block state
  typedef struct packed {
    logic [15:0][15:0] filt_sid;
    logic [15:0][15:0] filt_eid;
    logic [15:0] sel_low;
    logic [15:0] sel_high;
    logic [2:0][15:0] mask_sid;
    logic [2:0][15:0] mask_eid;
    logic aw_rdy;
    logic w_rdy;
    logic aw_full;
    logic w_full;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [7:0] rd_addr;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic hit_valid;
    logic [15:0] hit_vec;
  } caf_state_t;

endpackage

/* caf_filter.sv */
// acceptance filter bank with mask selection behind an axi4-lite slave
//
// Local design decisions: the register addresses and the AXI4-Lite slave port.
`timescale 1ns/10ps

// Operation
// - There are sixteen filters, each with a 16-bit low extended pattern.
// - A compared low extended bit matches only if it equals the pattern.
// - Selector 11 is no mask, 10 mask 2, 01 mask 1 and 00 mask 0.
// - Filters 0-7 select in the low register, 8-15 in the high, 2 bits each.
// - Both selection registers reset to zero so all filters use mask 0.
// - Three masks exist, each with a standard register of sid, mode, ext top.
// - A set standard mask bit compares that identifier bit, clear ignores it.
// - Mask bits 1-0 compare extended bits 17-16 when set, ignore when clear.
// - Mode one accepts only frames whose format equals the filter's setting.
// - Mode zero accepts either format when the identifier bits match.
// - Bits 4 and 2 of a mask standard register ignore writes and read zero.
// - The filter extended enable acts only in mode one, ext or std only.
// - Compared filter sid and top extended pattern bits must equal the frame bits.
// - Each mask has a 16-bit low extended mask register of compare bits.
module caf_filter (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // received frame from the bit engine, same clock
  input wire logic frame_valid,
  input wire caf_pkg::caf_frame_t frame,
  // filter results
  output logic hit_valid,
  output logic [15:0] hit_vec
);

  caf_pkg::caf_state_t s;
  caf_pkg::caf_state_t next_s;

  // byte lanes 0 and 1 only, registers are 16 bits wide
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] r;
    r = old;
    if (strb[0]) r[7:0] = data[7:0];
    if (strb[1]) r[15:8] = data[15:8];
    return r;
  endfunction

  // two-bit mask source of filter n
  function automatic logic [1:0] sel_of(input logic [15:0] lo,
                                        input logic [15:0] hi,
                                        input int n);
    logic [1:0] r;
    if (n < 8) r = lo[2*n +: 2];
    else r = hi[2*(n-8) +: 2];
    return r;
  endfunction

  // one filter against one frame
  function automatic logic filt_hit(input caf_pkg::caf_frame_t f,
                                    input logic [15:0] psid,
                                    input logic [15:0] peid,
                                    input logic [15:0] msid,
                                    input logic [15:0] meid,
                                    input logic [1:0] sel);
    logic [28:0] pat;
    logic [28:0] id;
    logic [28:0] cmp;
    logic mode;
    logic ok;
    pat = {psid[caf_pkg::SID_MSB:caf_pkg::SID_LSB],
           psid[caf_pkg::EXT_TOP_MSB:0], peid};
    id = {f.standard_identifier_bits, f.extended_identifier_bits};
    if (sel == caf_pkg::CAF_SEL_NONE) begin
      cmp = '1;
      mode = 1'b1;
    end else begin
      cmp = {msid[caf_pkg::SID_MSB:caf_pkg::SID_LSB],
             msid[caf_pkg::EXT_TOP_MSB:0], meid};
      mode = msid[caf_pkg::MODE_BIT];
    end
    // a standard frame carries no extended bits to compare
    if (!f.ext) cmp[17:0] = '0;
    ok = ((pat ^ id) & cmp) == '0;
    if (mode && (f.ext != psid[caf_pkg::MODE_BIT])) ok = 1'b0;
    return ok;
  endfunction

  // register read decode, returns {resp, data}
  function automatic logic [33:0] rd_word(input caf_pkg::caf_state_t st,
                                          input logic [7:0] a);
    logic [15:0] d;
    logic [1:0] resp;
    d = '0;
    resp = caf_pkg::RESP_OKAY;
    if (a < caf_pkg::ADDR_FILT_EID) d = st.filt_sid[a[5:2]];
    else if (a < caf_pkg::ADDR_SEL_LOW) d = st.filt_eid[a[5:2]];
    else if (a == caf_pkg::ADDR_SEL_LOW) d = st.sel_low;
    else if (a == caf_pkg::ADDR_SEL_HIGH) d = st.sel_high;
    else if (a >= caf_pkg::ADDR_MASK_SID && a[3:2] != 2'b11 &&
             a < caf_pkg::ADDR_MASK_EID) d = st.mask_sid[a[3:2]];
    else if (a >= caf_pkg::ADDR_MASK_EID && a[3:2] != 2'b11 &&
             a < caf_pkg::ADDR_HIT_STAT) d = st.mask_eid[a[3:2]];
    else if (a == caf_pkg::ADDR_HIT_STAT) d = st.hit_vec;
    else resp = caf_pkg::RESP_SLVERR;
    if (a == caf_pkg::ADDR_HIT_STAT) begin
      return {resp, 15'h0000, |st.hit_vec, d};
    end
    return {resp, 16'h0000, d};
  endfunction

  always_comb begin
    logic [7:0] a;
    logic [1:0] sl;
    logic [1:0] mi;
    a = s.aw_addr;
    sl = '0;
    mi = '0;
    next_s = s;

    // filtering, result held until the next frame
    next_s.hit_valid = frame_valid;
    if (frame_valid) begin
      for (int i = 0; i < caf_pkg::NUM_FILT; i++) begin
        sl = sel_of(s.sel_low, s.sel_high, i);
        mi = (sl == caf_pkg::CAF_SEL_NONE) ? 2'b00 : sl;
        next_s.hit_vec[i] = filt_hit(frame, s.filt_sid[i], s.filt_eid[i],
                                     s.mask_sid[mi], s.mask_eid[mi], sl);
      end
    end

    // write address and data may arrive in either order
    if (s_axi_awvalid && s.aw_rdy) begin
      next_s.aw_full = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.w_rdy) begin
      next_s.w_full = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) next_s.bvalid = 1'b0;
    if (s.aw_full && s.w_full && !s.bvalid) begin
      next_s.aw_full = 1'b0;
      next_s.w_full = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = caf_pkg::RESP_OKAY;
      if (a < caf_pkg::ADDR_FILT_EID) begin
        next_s.filt_sid[a[5:2]] = merge16(s.filt_sid[a[5:2]], s.w_data,
                                          s.w_strb) & caf_pkg::SID_REG_WMASK;
      end else if (a < caf_pkg::ADDR_SEL_LOW) begin
        next_s.filt_eid[a[5:2]] = merge16(s.filt_eid[a[5:2]], s.w_data,
                                          s.w_strb);
      end else if (a == caf_pkg::ADDR_SEL_LOW) begin
        next_s.sel_low = merge16(s.sel_low, s.w_data, s.w_strb);
      end else if (a == caf_pkg::ADDR_SEL_HIGH) begin
        next_s.sel_high = merge16(s.sel_high, s.w_data, s.w_strb);
      end else if (a >= caf_pkg::ADDR_MASK_SID && a[3:2] != 2'b11 &&
                   a < caf_pkg::ADDR_MASK_EID) begin
        next_s.mask_sid[a[3:2]] = merge16(s.mask_sid[a[3:2]], s.w_data,
                                   s.w_strb) & caf_pkg::SID_REG_WMASK;
      end else if (a >= caf_pkg::ADDR_MASK_EID && a[3:2] != 2'b11 &&
                   a < caf_pkg::ADDR_HIT_STAT) begin
        next_s.mask_eid[a[3:2]] = merge16(s.mask_eid[a[3:2]], s.w_data,
                                          s.w_strb);
      end else if (a != caf_pkg::ADDR_HIT_STAT) begin
        next_s.bresp = caf_pkg::RESP_SLVERR;
      end
    end
    // stall both write channels while a response is pending
    next_s.aw_rdy = !next_s.aw_full && !next_s.bvalid;
    next_s.w_rdy = !next_s.w_full && !next_s.bvalid;

    // read: one outstanding, data registered
    if (s.rvalid && s_axi_rready) next_s.rvalid = 1'b0;
    if (s_axi_arvalid && s.ar_rdy) begin
      next_s.rd_addr = s_axi_araddr;
      {next_s.rresp, next_s.rdata} = rd_word(s, s_axi_araddr);
      next_s.rvalid = 1'b1;
    end
    next_s.ar_rdy = !next_s.rvalid;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= caf_pkg::caf_state_t'('0);
    end else begin
      s <= next_s;
    end
  end

  assign s_axi_awready = s.aw_rdy;
  assign s_axi_wready = s.w_rdy;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.ar_rdy;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;
  assign hit_valid = s.hit_valid;
  assign hit_vec = s.hit_vec;

  // helpers for the checks on filter 0
  logic [1:0] sel0;
  logic [28:0] pat0;
  logic [28:0] fid;
  logic mask0_open;
  logic [28:0] msk0;
  assign msk0 = {s.mask_sid[0][15:5], s.mask_sid[0][1:0], s.mask_eid[0]};
  assign sel0 = sel_of(s.sel_low, s.sel_high, 0);
  assign pat0 = {s.filt_sid[0][15:5], s.filt_sid[0][1:0], s.filt_eid[0]};
  assign fid = {frame.standard_identifier_bits, frame.extended_identifier_bits};
  assign mask0_open = (s.mask_sid[0] == '0) && (s.mask_eid[0] == '0);

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_sel_reset_zero: assert property (
    $rose(aresetn) |-> (s.sel_low == '0 && s.sel_high == '0))
    else $error("mask selection not zero after reset");

  chk_nomask_mismatch: assert property (
    frame_valid && sel0 == 2'b11 && frame.ext && pat0 != fid
    |=> hit_valid && !hit_vec[0])
    else $error("filter 0 hit despite differing identifier");

  chk_nomask_exact_hit: assert property (
    frame_valid && sel0 == 2'b11 && frame.ext && pat0 == fid &&
    s.filt_sid[0][3] |=> hit_valid && hit_vec[0])
    else $error("filter 0 missed an exact extended match");

  chk_std_sid_compare: assert property (
    frame_valid && sel0 == 2'b11 && !frame.ext &&
    s.filt_sid[0][15:5] != frame.standard_identifier_bits |=> !hit_vec[0])
    else $error("standard frame hit with wrong sid");

  chk_open_mask_hit: assert property (
    frame_valid && sel0 == 2'b00 && mask0_open |=> hit_vec[0])
    else $error("all-ignore mask did not accept frame");

  chk_mode_format: assert property (
    frame_valid && sel0 == 2'b00 && s.mask_sid[0][3] &&
    frame.ext != s.filt_sid[0][3] |=> !hit_vec[0])
    else $error("frame format mismatch accepted in mode one");

  chk_unimpl_read_zero: assert property (
    $rose(s_axi_rvalid) && s.rd_addr[7:4] == 4'h9
    |-> s_axi_rdata[4] == 1'b0 && s_axi_rdata[2] == 1'b0)
    else $error("unimplemented mask bits read nonzero");

  chk_hit_one_cycle: assert property (
    frame_valid |=> hit_valid ##1 (hit_valid == $past(frame_valid)))
    else $error("hit valid not one cycle after frame");

  chk_write_resp: assert property (
    s.aw_full && s.w_full && !s.bvalid |=> s_axi_bvalid)
    else $error("write response missing");

  chk_outputs_reset: assert property (
    $rose(aresetn) |-> !s_axi_awready && !s_axi_arready && !s_axi_bvalid &&
    !s_axi_rvalid && !hit_valid)
    else $error("outputs not idle after reset");

  chk_aw_stall: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write channel ready while response pending");

  chk_ar_stall: assert property (
    s_axi_rvalid |-> !s_axi_arready)
    else $error("read address ready while data pending");

  chk_b_after_pair: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid)
    else $error("write response late");

  chk_r_after_ar: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");

  chk_b_release: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not released");

  chk_r_release: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read data not released");

  chk_sel_low_write: assert property (
    s.aw_full && s.w_full && !s.bvalid && s.w_strb[1:0] == 2'b11 &&
    s.aw_addr == caf_pkg::ADDR_SEL_LOW
    |=> s.sel_low == $past(s.w_data[15:0]))
    else $error("selection low write lost");

  chk_sel_high_write: assert property (
    s.aw_full && s.w_full && !s.bvalid && s.w_strb[1:0] == 2'b11 &&
    s.aw_addr == caf_pkg::ADDR_SEL_HIGH
    |=> s.sel_high == $past(s.w_data[15:0]))
    else $error("selection high write lost");

  chk_masked_hit: assert property (
    frame_valid && sel0 == 2'b00 && !s.mask_sid[0][3] && frame.ext &&
    ((pat0 ^ fid) & msk0) == '0 |=> hit_vec[0])
    else $error("masked equal identifier missed");

  chk_masked_miss: assert property (
    frame_valid && sel0 == 2'b00 && frame.ext &&
    ((pat0 ^ fid) & msk0) != '0 |=> !hit_vec[0])
    else $error("masked differing identifier accepted");

  chk_std_skips_eid: assert property (
    frame_valid && !frame.ext && sel0 == 2'b00 && !s.mask_sid[0][3] &&
    ((s.filt_sid[0][15:5] ^ frame.standard_identifier_bits) & s.mask_sid[0][15:5]) == '0
    |=> hit_vec[0])
    else $error("standard frame missed on sid match");

  chk_hit_vec_hold: assert property (
    !frame_valid |=> $stable(hit_vec))
    else $error("hit vector changed without a frame");

  chk_hit_idle: assert property (
    !frame_valid |=> !hit_valid)
    else $error("hit strobe without a frame");

  chk_sel_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == caf_pkg::ADDR_SEL_HIGH
    |=> s_axi_rdata == {16'h0000, $past(s.sel_high)})
    else $error("selection high read wrong");

  chk_unmapped_read: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr > caf_pkg::ADDR_HIT_STAT
    |=> s_axi_rresp == caf_pkg::RESP_SLVERR && s_axi_rdata == '0)
    else $error("unmapped read not refused");

  chk_hit_any_bit: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr == caf_pkg::ADDR_HIT_STAT
    |=> s_axi_rdata[caf_pkg::HIT_ANY_BIT] == |$past(s.hit_vec))
    else $error("any-hit status bit wrong");

  cov_ext_hit: cover property (frame_valid && frame.ext ##1 |hit_vec);
  cov_std_hit: cover property (frame_valid && !frame.ext ##1 |hit_vec);
  cov_mode_one: cover property (frame_valid && s.mask_sid[0][3]);
  cov_read_stat: cover property (s_axi_rvalid &&
                                 s.rd_addr == caf_pkg::ADDR_HIT_STAT);
  cov_nomask_hit: cover property (frame_valid && sel0 == 2'b11 ##1 hit_vec[0]);

endmodule // caf_filter

/* caf_can_src.sv */
// frame source standing in for the can bus receive path
`timescale 1ns/10ps
module caf_can_src (
  // clock
  input wire logic aclk,
  // frame to the filter
  output logic frame_valid,
  output caf_pkg::caf_frame_t frame
);
  initial begin
    frame_valid = 1'b0;
    frame = '1;
  end
  // outside a frame the id lines carry junk, never the last id
  task automatic send(input caf_pkg::caf_frame_t f);
    @(posedge aclk);
    frame_valid <= 1'b1;
    frame <= f;
    @(posedge aclk);
    frame_valid <= 1'b0;
    frame <= ~f;
  endtask
endmodule // caf_can_src

/* can_acceptance_filter_mask_tb.sv */
// testbench for the can acceptance filter block
`timescale 1ns/10ps
module can_acceptance_filter_mask_tb;
  logic aclk = 0;
  logic aresetn = 0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, frame_valid, hit_valid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rd_v;
  logic [15:0] hit_vec, sel_lo, sel_hi;
  logic [15:0] fsid [16], feid [16], msid [3], meid [3];
  caf_pkg::caf_frame_t frame;
  int err_count = 0, n_checks = 0, cyc = 0;

  always #25 aclk = ~aclk;

  caf_filter u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .frame_valid, .frame,
    .hit_valid, .hit_vec);
  caf_can_src u_src (.aclk, .frame_valid, .frame);

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // a hung handshake ends here instead of running forever
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end

  task automatic chk(input logic [31:0] got, exp, input string m);
    n_checks++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s = 4'hf);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    forever begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid) break;
    end
    rd_v = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  // reference match, worked out from the register fields
  function automatic logic hit_f(int n, caf_pkg::caf_frame_t f);
    logic [1:0] s;
    logic [15:0] ms, me;
    logic [28:0] m;
    s = n < 8 ? sel_lo[2*n +: 2] : sel_hi[2*n-16 +: 2];
    ms = s == 2'b11 ? 16'hffff : msid[s];
    me = s == 2'b11 ? 16'hffff : meid[s];
    m = {ms[15:5], ms[1:0], me};
    if (!f.ext) m[17:0] = '0;
    if (ms[3] && f.ext !== fsid[n][3]) return 0;
    return (({fsid[n][15:5], fsid[n][1:0], feid[n]} ^ {f.standard_identifier_bits, f.extended_identifier_bits})
      & m) == 0;
  endfunction

  task automatic send(input caf_pkg::caf_frame_t f);
    logic [15:0] ev;
    for (int i = 0; i < 16; i++) ev[i] = hit_f(i, f);
    u_src.send(f);
    // the strobe is launched at the edge that ends the frame
    @(posedge aclk);
    chk(hit_valid, 1, "hit strobe");
    chk(hit_vec, ev, "hit vector");
  endtask

  task automatic t_reset();
    rd(caf_pkg::ADDR_SEL_LOW);
    chk(rd_v, 32'h0000_0000, "select low reset");
    rd(caf_pkg::ADDR_SEL_HIGH);
    chk(rd_v, 32'h0000_0000, "select high reset");
    $display("test reset done");
  endtask

  task automatic t_regs();
    wr(caf_pkg::ADDR_MASK_SID + 8'h04, 32'h0000_ffff);
    chk(rsp, caf_pkg::RESP_OKAY, "mask write");
    rd(caf_pkg::ADDR_MASK_SID + 8'h04);
    chk(rd_v, 32'h0000_ffeb, "mask sid");
    wr(caf_pkg::ADDR_MASK_EID + 8'h08, 32'h0000_ffff);
    rd(caf_pkg::ADDR_MASK_EID + 8'h08);
    chk(rd_v, 32'h0000_ffff, "mask eid");
    wr(caf_pkg::ADDR_FILT_EID + 8'h3c, 32'h1234_abcd, 4'b0001);
    rd(caf_pkg::ADDR_FILT_EID + 8'h3c);
    chk(rd_v, 32'h0000_00cd, "pattern lane");
    wr(8'hfc, 32'h0000_ffff);
    chk(rsp, caf_pkg::RESP_SLVERR, "unmapped write");
    rd(8'hfc);
    chk(rsp, caf_pkg::RESP_SLVERR, "unmapped read");
    $display("test registers done");
  endtask

  // registers at reset value: mask 0 ignores every bit, mode zero
  task automatic t_zero();
    caf_pkg::caf_frame_t f;
    sel_lo = '0;
    sel_hi = '0;
    for (int i = 0; i < 16; i++) begin
      fsid[i] = '0;
      feid[i] = '0;
    end
    msid = '{default: '0};
    meid = '{default: '0};
    f = '{ext: 1'b1, standard_identifier_bits: 11'h5a5, extended_identifier_bits: 18'h2_5a5a};
    send(f);
    f.ext = 1'b0;
    send(f);
    rd(caf_pkg::ADDR_HIT_STAT);
    chk(rd_v, 32'h0001_ffff, "hit status");
    $display("test open masks done");
  endtask

  task automatic t_match();
    caf_pkg::caf_frame_t f;
    msid = '{16'hffeb, 16'hff03, 16'h0008};
    meid = '{16'hffff, 16'h00ff, 16'h0000};
    for (int m = 0; m < 3; m++) begin
      wr(caf_pkg::ADDR_MASK_SID + 8'(4*m), {16'h0000, msid[m]});
      wr(caf_pkg::ADDR_MASK_EID + 8'(4*m), {16'h0000, meid[m]});
    end
    for (int n = 0; n < 16; n++) begin
      fsid[n] = (16'(n * 32'h0000_1357) & 16'hffeb) ^ 16'h0008;
      feid[n] = 16'(n * 32'h0000_2468);
      wr(caf_pkg::ADDR_FILT_SID + 8'(4*n), {16'h0000, fsid[n]});
      wr(caf_pkg::ADDR_FILT_EID + 8'(4*n), {16'h0000, feid[n]});
    end
    // each filter gets one selector code and its complement over the two passes
    for (int p = 0; p < 2; p++) begin
      sel_lo = p == 0 ? 16'he4e4 : 16'h1b1b;
      sel_hi = p == 0 ? 16'h1b1b : 16'he4e4;
      wr(caf_pkg::ADDR_SEL_LOW, {16'h0000, sel_lo});
      wr(caf_pkg::ADDR_SEL_HIGH, {16'h0000, sel_hi});
      rd(caf_pkg::ADDR_SEL_HIGH);
      chk(rd_v, {16'h0000, sel_hi}, "select high");
      // exact id, wrong format, one sid and one extended bit off, then both
      for (int n = 0; n < 16; n++) begin
        for (int k = 0; k < 4; k++) begin
          f.ext = fsid[n][3] ^ (k % 2 == 1);
          f.standard_identifier_bits = fsid[n][15:5] ^ (k >= 2 ? 11'h001 << (n % 11) : 11'h000);
          f.extended_identifier_bits = {fsid[n][1:0], feid[n]} ^ (k >= 2 ? 18'h1 << n : 18'h0);
          send(f);
        end
      end
    end
    $display("test matching done");
  endtask

  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset();
    t_zero();
    t_regs();
    t_match();
    // a reset in mid-run must clear the selectors written above
    aresetn <= 0;
    repeat (2) @(posedge aclk);
    aresetn <= 1;
    repeat (2) @(posedge aclk);
    t_reset();
    report_and_stop();
  end
endmodule // can_acceptance_filter_mask_tb
